// File: core/ucdb_pkg.sv
package ucdb_pkg;

    // ****************************************
    // Register indexes (byte address = 4 * index)
    // ****************************************
    localparam logic [7:0] IDX_CTRL = 8'h98;
    localparam logic [7:0] IDX_DATA = 8'h99;
    localparam logic [7:0] IDX_BAUD = 8'h9A;
    localparam logic [7:0] IDX_ISTAT = 8'h9B;
    localparam logic [7:0] IDX_IMASK = 8'h9C;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CB_MODE = 7;
    localparam int CB_ONE = 6;
    localparam int CB_MCE = 5;
    localparam int CB_REN = 4;
    localparam int CB_TB8 = 3;
    localparam int CB_RB8 = 2;
    localparam int CB_TI = 1;
    localparam int CB_RI = 0;
    localparam logic [7:0] CTRL_RST = 8'h40;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam int BB_TSEL = 8;
    localparam int BB_PSC = 9;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam int IB_RX = 0;
    localparam int IB_TX = 1;

    // ****************************************
    // Timing counts
    // ****************************************
    localparam logic [5:0] PSC_DIV12 = 6'h0C;
    localparam logic [5:0] PSC_DIV4 = 6'h04;
    localparam logic [5:0] PSC_DIV48 = 6'h30;
    localparam logic [5:0] PSC_DIV8 = 6'h08;
    localparam logic [7:0] TMR_TOP = 8'hFF;
    localparam logic [3:0] BIT_START = 4'h0;
    localparam logic [3:0] BIT_LASTDATA = 4'h8;
    localparam logic [3:0] BIT_STOP8 = 4'h9;
    localparam logic [3:0] BIT_STOP9 = 4'hA;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] reload;
        logic tmrSel;
        logic [1:0] psc;
        logic [1:0] iStat;
        logic [1:0] iMask;
        logic [7:0] rxLatch;
        logic [5:0] pscCnt;
        logic txBusy;
        logic [8:0] txShift;
        logic [3:0] txBit;
        logic txHalf;
        logic [7:0] txCnt;
        logic txd;
        logic rxS1;
        logic rxS2;
        logic rxS3;
        logic rxBusy;
        logic [3:0] rxBit;
        logic rxHalf;
        logic [7:0] rxCnt;
        logic [8:0] rxShift;
        logic ack;
        logic [31:0] dat;
        logic irq;
    } ucdb_state_t;

endpackage

// File: core/ucdb_top.sv
// The Wishbone register port was decided locally.
`timescale 1ns/10ps

module ucdb_top
    import ucdb_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic rxd,
    output logic txd,
    output logic irq
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (ADDR_W < 10) begin : g_chk
        $error("ADDR_W must be at least 10");
    end

    function automatic logic [5:0] pscDiv(input logic [1:0] code);
        logic [5:0] d;
        d = PSC_DIV12;
        unique case (code)
            2'b00: d = PSC_DIV12;
            2'b01: d = PSC_DIV4;
            2'b10: d = PSC_DIV48;
            2'b11: d = PSC_DIV8;
        endcase
        return d;
    endfunction

    ucdb_state_t q;
    ucdb_state_t d;

    logic req;
    logic wrLane;
    logic [7:0] idx;
    logic [7:0] wd;
    logic tick;
    logic txOv;
    logic rxOv;
    logic mode9;
    logic stopBit;
    logic accept;
    logic [3:0] txNext;

    assign dat_o = q.dat;
    assign ack_o = q.ack;
    assign txd = q.txd;
    assign irq = q.irq;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        req = cyc_i & stb_i & ~q.ack;
        wrLane = req & we_i & sel_i[0];
        idx = adr_i[9:2];
        wd = dat_i[7:0];
        mode9 = q.ctrl[CB_MODE];
        stopBit = 1'b0;
        accept = 1'b0;
        txNext = q.txBit + 4'h1;

        // Timer clock: system clock or prescaled system clock
        if (q.pscCnt == pscDiv(q.psc) - 6'h01) begin
            d.pscCnt = 6'h00;
        end else begin
            d.pscCnt = q.pscCnt + 6'h01;
        end
        tick = q.tmrSel | (q.pscCnt == pscDiv(q.psc) - 6'h01);

        // Each direction has its own reload timer so a frame starts
        // with a full start bit rather than a random fraction.
        txOv = tick & (q.txCnt == TMR_TOP);
        rxOv = tick & (q.rxCnt == TMR_TOP);
        if (tick) begin
            d.txCnt = txOv ? q.reload : q.txCnt + 8'h01;
            d.rxCnt = rxOv ? q.reload : q.rxCnt + 8'h01;
        end

        // ****************************************
        // Bus writes (hardware sets below win)
        // ****************************************
        d.ack = req;
        if (req) begin
            d.dat = 32'h0000_0000;
            unique case (idx)
                IDX_CTRL: d.dat[7:0] = q.ctrl;
                IDX_DATA: d.dat[7:0] = q.rxLatch;
                IDX_BAUD: d.dat[10:0] = {q.psc, q.tmrSel, q.reload};
                IDX_ISTAT: d.dat[1:0] = q.iStat;
                IDX_IMASK: d.dat[1:0] = q.iMask;
                default: d.dat = 32'h0000_0000;
            endcase
        end
        if (wrLane) begin
            unique case (idx)
                IDX_CTRL: begin
                    // Writing 0 to a done flag is the only clear
                    d.ctrl = {wd[7], 1'b1, wd[5:0]};
                end
                IDX_DATA: begin
                    // Restart on write, even mid-frame
                    d.txBusy = 1'b1;
                    d.txShift = {q.ctrl[CB_TB8], wd};
                    d.txBit = BIT_START;
                    d.txd = 1'b0;
                    d.txHalf = 1'b0;
                    d.txCnt = q.reload;
                end
                IDX_BAUD: begin
                    d.reload = wd;
                    if (sel_i[1]) begin
                        d.tmrSel = dat_i[BB_TSEL];
                        d.psc = dat_i[BB_PSC+:2];
                    end
                end
                IDX_ISTAT: d.iStat = q.iStat & ~wd[1:0];
                IDX_IMASK: d.iMask = wd[1:0];
                default: d.iMask = q.iMask;
            endcase
        end

        // ****************************************
        // Transmitter
        // ****************************************
        // Two overflows make one bit time
        if (q.txBusy && !(wrLane && idx == IDX_DATA) && txOv) begin
            d.txHalf = ~q.txHalf;
            if (q.txHalf) begin
                d.txBit = txNext;
                if (txNext <= BIT_LASTDATA) begin
                    d.txd = q.txShift[0];
                    d.txShift = {1'b0, q.txShift[8:1]};
                end else if (txNext == BIT_STOP8 && mode9) begin
                    d.txd = q.txShift[0];
                end else if (txNext == (mode9 ? BIT_STOP9 : BIT_STOP8)) begin
                    d.txd = 1'b1;
                    d.ctrl[CB_TI] = 1'b1;
                    d.iStat[IB_TX] = 1'b1;
                end else begin
                    d.txBusy = 1'b0;
                end
            end
        end

        // ****************************************
        // Receiver
        // ****************************************
        d.rxS1 = rxd;
        d.rxS2 = q.rxS1;
        d.rxS3 = q.rxS2;
        if (!q.ctrl[CB_REN]) begin
            d.rxBusy = 1'b0;
        end else if (!q.rxBusy) begin
            if (q.rxS3 && !q.rxS2) begin
                d.rxBusy = 1'b1;
                d.rxBit = BIT_START;
                d.rxHalf = 1'b0;
                d.rxCnt = q.reload;
            end
        end else if (rxOv) begin
            d.rxHalf = ~q.rxHalf;
            // Sample in the middle of each bit
            if (!q.rxHalf) begin
                d.rxBit = q.rxBit + 4'h1;
                if (q.rxBit == BIT_START) begin
                    d.rxBusy = ~q.rxS2;
                end else if (q.rxBit <= BIT_LASTDATA) begin
                    d.rxShift[7:0] = {q.rxS2, q.rxShift[7:1]};
                end else if (q.rxBit == BIT_STOP8 && mode9) begin
                    d.rxShift[8] = q.rxS2;
                end else begin
                    stopBit = q.rxS2;
                    d.rxBusy = 1'b0;
                    // In 8-bit mode the filter checks the stop bit
                    accept = !q.ctrl[CB_MCE] |
                        (mode9 ? q.rxShift[8] : stopBit);
                    if (accept) begin
                        d.rxLatch = q.rxShift[7:0];
                        d.ctrl[CB_RB8] = mode9 ? q.rxShift[8] : stopBit;
                        d.ctrl[CB_RI] = 1'b1;
                        d.iStat[IB_RX] = 1'b1;
                    end
                end
            end
        end

        // Interrupt level, gated by the mask
        d.irq = |(q.iStat & q.iMask);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.ctrl <= CTRL_RST;
            q.reload <= RELOAD_RST;
            q.rxLatch <= DATA_RST;
            q.txd <= 1'b1;
            q.rxS1 <= 1'b1;
            q.rxS2 <= 1'b1;
            q.rxS3 <= 1'b1;
        end else begin
            q <= d;
        end
    end

endmodule

// File: tb/ucdb_remote.sv
`timescale 1ns/10ps
module ucdb_remote #(
    parameter int BT = 4
) (
    input wire logic sys_clk,
    input wire logic txd,
    output logic rxd
);
    // Idle line rests high, as with the pin pull-up
    initial rxd = 1'b1;
    task automatic send(input logic [8:0] v, input int nb);
        for (int i = -1; i <= nb; i++) begin
            @(posedge sys_clk);
            rxd <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : v[i];
            repeat (BT - 1) @(posedge sys_clk);
        end
    endtask
    // Samples mid-bit; bit nb of v is the stop bit
    task automatic recv(input int nb, output logic [9:0] v);
        int n;
        n = 0;
        v = '1;
        while (txd !== 1'b0 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (BT / 2) @(posedge sys_clk);
        for (int i = 0; i <= nb; i++) begin
            repeat (BT) @(posedge sys_clk);
            v[i] = txd;
        end
    endtask
endmodule

// File: tb/ucdb_top_assertions.sv
`timescale 1ns/10ps
module ucdb_chk
    import ucdb_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic rxd,
    input wire logic txd,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic take;
    logic [7:0] idx;
    assign take = cyc_i && stb_i && !ack_o;
    assign idx = adr_i[9:2];
    sequence s_wr(logic [7:0] i);
        take && we_i && sel_i[0] && idx == i;
    endsequence
    sequence s_rd(logic [7:0] i);
        take && !we_i && idx == i;
    endsequence
    property p_ack;
        take |=> ack_o ##1 !ack_o;
    endproperty
    property p_tx;
        s_wr(IDX_DATA) |=> (!txd) [*2];
    endproperty
    property p_unmap;
        take && !we_i && (idx < IDX_CTRL || idx > IDX_IMASK) |=> dat_o == 0;
    endproperty
    property p_ctrl;
        s_rd(IDX_CTRL) |=> dat_o[6] && dat_o[31:8] == 24'h0;
    endproperty
    property p_mask;
        s_wr(IDX_IMASK) ##0 dat_i[1:0] == 2'h0 |=> ##1 !irq;
    endproperty
    property p_fall;
        $fell(irq) |-> $past(take && we_i, 2);
    endproperty
    property p_hold;
        !take |=> $stable(dat_o);
    endproperty
    property p_rst;
        $fell(rst) |-> txd && !irq && !ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus answer not one cycle");
    a_tx: assert property (p_tx)
        else $error("no start bit after data write");
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    a_ctrl: assert property (p_ctrl)
        else $error("control read bad fixed bits");
    a_mask: assert property (p_mask)
        else $error("masked interrupt still high");
    a_fall: assert property (p_fall)
        else $error("interrupt dropped without software");
    a_hold: assert property (p_hold)
        else $error("read data changed while idle");
    a_rst: assert property (p_rst)
        else $error("outputs not idle after reset");
endmodule
bind ucdb_top ucdb_chk #(.ADDR_W(ADDR_W)) chk (.sys_clk(sys_clk),
    .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rxd(rxd), .txd(txd), .irq(irq));

// File: tb/ucdb_top_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, a) begin nChecks++; if ((a) !== (e)) begin \
    errCount++; $display("wrong value %s exp %0h got %0h", nm, e, a); end end
module ucdb_top_tb
    import ucdb_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = '0;
    logic [31:0] datI = '0;
    logic [31:0] datO, rd;
    logic ack, rxd, txd, irq;
    logic [9:0] fr;
    logic [31:0] seed = 32'h00000057;
    logic [7:0] b, c, last;
    logic [4:0] t;
    // Fields: mode, filter, enable, ninth, accepted
    // Disabled frame and unfiltered ninth-bit zero frame are the corners
    logic [4:0] rxCase [5] = '{5'h05, 5'h00, 5'h1C, 5'h1F, 5'h15};
    logic [3:0] sel = 4'hF;
    int errCount = 0;
    int nChecks = 0;
    always #50 clk = ~clk;
    ucdb_top uut (.sys_clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO),
        .ack_o(ack), .rxd(rxd), .txd(txd), .irq(irq));
    ucdb_remote #(.BT(4)) far (.sys_clk(clk), .txd(txd), .rxd(rxd));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] rxCtrl(logic [7:0] k, logic n);
        return {24'h0, k | 8'h41 | {5'h0, n, 2'h0}};
    endfunction
    task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'b00, i, 2'b00};
        datI <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        // A bus answer that never comes is a mismatch, not a silent pass
        if (ack !== 1'b1) begin
            errCount++;
        end
        rd = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] i, input logic [31:0] e);
        wb(1'b0, i, 32'h0);
        `CHK("register", e, rd)
    endtask
    task automatic endSim();
        $display("checks %0d errors %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        last = 8'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdChk(IDX_CTRL, 32'h40);
        rdChk(IDX_DATA, 32'h0);
        wb(1'b1, 8'h10, 32'hFF);
        rdChk(8'h10, 32'h0);
        // Sys clock, reload 0xFE: four cycles a bit keeps frames short
        wb(1'b1, IDX_BAUD, 32'h1FE);
        rdChk(IDX_BAUD, 32'h1FE);
        // Low byte lane off: the write must not land
        sel <= 4'hE;
        wb(1'b1, IDX_BAUD, 32'h0);
        sel <= 4'hF;
        rdChk(IDX_BAUD, 32'h1FE);
        wb(1'b1, IDX_IMASK, 32'h3);
        for (int m = 0; m < 4; m++) begin
            rd = rnd();
            b = rd[7:0];
            c = {m[1], 3'b0, m[0], 3'b0};
            wb(1'b1, IDX_CTRL, {24'h0, c});
            wb(1'b1, IDX_DATA, {24'h0, b});
            far.recv(8 + m[1], fr);
            `CHK("frame", m[1] ? {1'b1, m[0], b} : {2'b11, b}, fr)
            rdChk(IDX_CTRL, {24'h0, c | 8'h42});
            `CHK("irq", 1'b1, irq)
            wb(1'b1, IDX_CTRL, {24'h0, c});
            wb(1'b1, IDX_ISTAT, 32'h3);
            rdChk(IDX_CTRL, {24'h0, c | 8'h40});
            `CHK("irq", 1'b0, irq)
        end
        for (int k = 0; k < 5; k++) begin
            t = rxCase[k];
            c = {t[4], 1'b0, t[3], t[2], 4'h0};
            wb(1'b1, IDX_CTRL, {24'h0, c});
            rd = rnd();
            b = rd[7:0];
            far.send({t[1], b}, t[4] ? 9 : 8);
            repeat (6) @(posedge clk);
            if (t[0]) last = b;
            rdChk(IDX_DATA, {24'h0, last});
            rdChk(IDX_CTRL, t[0] ? rxCtrl(c, t[4] ? t[1] : 1'b1)
                : {24'h0, c | 8'h40});
            `CHK("irq", t[0], irq)
            wb(1'b1, IDX_ISTAT, 32'h3);
        end
        wb(1'b1, IDX_IMASK, 32'h0);
        wb(1'b1, IDX_DATA, 32'h5A);
        far.recv(8, fr);
        rdChk(IDX_ISTAT, 32'h2);
        `CHK("irq", 1'b0, irq)
        endSim();
    end
    initial begin
        repeat (5000) @(posedge clk);
        errCount++;
        endSim();
    end
endmodule
